/* hw/ufc_ctrl.sv */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Interrupt when flag, mask set, global enabled
// - Event flags except CTR set by hardware, cleared by software; CTR tracks done bit and ep 1-5 transfer pulse
// - Bit 7 shows resume started during suspend
// - Bit 6 shows bus reset sequence started
// - Resume bit drives resume signalling on bus
// - Power-down turns regulator off; reset value 06h
// - Forced suspend; hardware clears on bus activity
// - Force reset holds interface; release raises reset
// - Seven-bit node number, cleared by bus reset
// - Capture upper PID bits of endpoint 0 token
// - Direction bit for endpoints 1 to 5
// - Endpoint number 0 to 5 in bits 2:0
// - Three-bit fault code values
// - Fault code loaded on error, zeroed on clear
// - Control pipe toggle and handshake fields cleared by bus reset; done bit kept
// - Done bit set per correct transfer, feeds CTR
// - Transmit toggle: set on SETUP, flips on ACK
// - Transmit handshake coding disabled/stall/nak/valid
// - Both handshake fields forced NAK after transfer
// - Receive toggle cleared at setup, flips on data
// - Receive handshake uses same coding
// - SETUP acknowledged when enabled, fields to NAK
module ufc_ctrl (
   input wire logic pclk,                   // Clock
   input wire logic presetn,                // Async reset, low
   input wire logic clk_en,                 // Freeze when low
   input wire logic psel,                   // APB select
   input wire logic penable,                // APB enable
   input wire logic pwrite,                 // APB direction
   input wire logic [11:0] paddr,           // APB address
   input wire logic [31:0] pwdata,          // APB write data
   output logic [31:0] prdata,              // APB read data
   output logic pready,                     // APB ready
   output logic pslverr,                    // APB error
   input wire logic cpu_irq_disable,        // Global disable bit
   input wire ufc_pkg::ufc_line_s line_in,  // Bus line events
   input wire ufc_pkg::ufc_token_s token_in, // Decoded token
   input wire ufc_pkg::ufc_result_s result_in, // Transaction result
   input wire ufc_pkg::ufc_fault_s fault_in, // Error report
   input wire logic [2:0] other_ep_done,    // Ep 1-5 number done
   input wire logic other_ep_valid,         // Ep 1-5 transfer done
   output logic irq,                        // Interrupt request
   output logic resume_drive,               // Drive resume on bus
   output logic regulator_off,              // Regulator disabled
   output logic suspended,                  // Interface suspended
   output logic iface_reset,                // Interface in reset
   output logic [1:0] ep0_handshake,        // Reply for ep0
   output logic ep0_reply_valid,            // One-cycle reply
   output logic ep0_toggle                  // Expected data toggle
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] flags_q, flags_d;
   logic [7:0] mask_q;
   logic [7:0] lctl_q, lctl_d;
   logic [6:0] node_q;
   logic [7:0] last_q, last_d;
   logic [2:0] fault_q, fault_d;
   logic done_q, done_d;
   logic txtog_q, txtog_d;
   logic rxtog_q, rxtog_d;
   logic [1:0] txhs_q, txhs_d;
   logic [1:0] rxhs_q, rxhs_d;
   logic [2:0] cur_ep_q;
   logic [1:0] cur_pid_q;
   logic suspend_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire wr_acc = psel && penable && pwrite && clk_en;
   wire rd_acc = psel && !penable && !pwrite && clk_en;
   wire hit_flags = paddr == ufc_pkg::OFF_EVENT_FLAGS;
   wire hit_mask = paddr == ufc_pkg::OFF_EVENT_MASK;
   wire hit_lctl = paddr == ufc_pkg::OFF_LINK_CONTROL;
   wire hit_node = paddr == ufc_pkg::OFF_NODE_ID;
   wire hit_last = paddr == ufc_pkg::OFF_LAST_XFER;
   wire hit_fault = paddr == ufc_pkg::OFF_FAULT_KIND;
   wire hit_pipe = paddr == ufc_pkg::OFF_CONTROL_PIPE;
   wire hit_any = hit_flags | hit_mask | hit_lctl | hit_node |
      hit_last | hit_fault | hit_pipe;
   wire [7:0] wd = pwdata[7:0];
   wire wr_flags = wr_acc && hit_flags;
   wire wr_lctl = wr_acc && hit_lctl;
   wire wr_pipe = wr_acc && hit_pipe;

   // ----------------------------------------------------------------
   // Interface reset and token qualification
   // ----------------------------------------------------------------
   wire force_interface_reset = lctl_q[ufc_pkg::LC_FORCE_RESET];
   wire usb_rst = line_in.bus_reset || force_interface_reset;
   wire force_interface_reset_release = wr_lctl && force_interface_reset &&
      !wd[ufc_pkg::LC_FORCE_RESET];
   wire tok_mine = token_in.valid && !usb_rst &&
      token_in.node == node_q;
   wire tok_ep0 = tok_mine && token_in.ep == 3'h0;
   wire is_setup = token_in.pid == ufc_pkg::PID_SETUP;
   wire [1:0] dir_hs = (token_in.pid == ufc_pkg::PID_IN) ?
      txhs_q : rxhs_q;
   // Disabled pipe ignores everything; SETUP overrides stall/nak
   wire [1:0] reply_hs = (dir_hs == ufc_pkg::HS_DISABLED &&
      !(is_setup && (txhs_q != ufc_pkg::HS_DISABLED ||
      rxhs_q != ufc_pkg::HS_DISABLED))) ? ufc_pkg::HS_DISABLED :
      is_setup ? ufc_pkg::HS_VALID : dir_hs;
   wire ep0_ok = result_in.ok && cur_ep_q == 3'h0;
   wire ctr_ev = ep0_ok || other_ep_valid;

   // ----------------------------------------------------------------
   // Event flags
   // ----------------------------------------------------------------
   logic [7:0] set_ev;
   always_comb begin
      set_ev = 8'h00;
      set_ev[ufc_pkg::EV_SOVR] = ep0_ok && done_q &&
         cur_pid_q == ufc_pkg::PID_SETUP;
      set_ev[ufc_pkg::EV_ERR] = fault_in.valid;
      set_ev[ufc_pkg::EV_SUSP] = line_in.idle_susp && !suspend_q;
      set_ev[ufc_pkg::EV_SUSPEND_EXIT_EVENT] = suspend_q && line_in.activity;
      set_ev[ufc_pkg::EV_RESET] = line_in.bus_reset || force_interface_reset_release;
      set_ev[ufc_pkg::EV_SOF] = line_in.sof;
   end
   // Write zero clears all but CTR; a set in the same cycle wins
   wire [7:0] clr_ev = wr_flags ? ~wd : 8'h00;
   always_comb begin
      flags_d = ((flags_q & ~clr_ev) | set_ev) &
         ufc_pkg::EV_VALID_MASK;
      flags_d[ufc_pkg::EV_CTR] = done_d || other_ep_valid;
   end

   // ----------------------------------------------------------------
   // Link control
   // ----------------------------------------------------------------
   always_comb begin
      lctl_d = lctl_q;
      if (wr_lctl) begin
         lctl_d[3:0] = wd[3:0];
      end
      lctl_d[5:4] = 2'h0;
      if (line_in.activity && suspend_q) begin
         lctl_d[ufc_pkg::LC_FORCED_SLEEP] = 1'b0;
      end
      if (line_in.resume && suspend_q) begin
         lctl_d[ufc_pkg::LC_RESUME_SEEN] = 1'b1;
      end else if (wr_lctl && !wd[ufc_pkg::LC_RESUME_SEEN]) begin
         lctl_d[ufc_pkg::LC_RESUME_SEEN] = 1'b0;
      end
      if (line_in.bus_reset) begin
         lctl_d[ufc_pkg::LC_BUS_RESET_SEEN] = 1'b1;
      end else if (wr_lctl && !wd[ufc_pkg::LC_BUS_RESET_SEEN]) begin
         lctl_d[ufc_pkg::LC_BUS_RESET_SEEN] = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Transfer info and fault code
   // ----------------------------------------------------------------
   always_comb begin
      last_d = last_q;
      if (ep0_ok && !set_ev[ufc_pkg::EV_SOVR]) begin
         last_d[7:6] = cur_pid_q;
         last_d[2:0] = 3'h0;
      end else if (other_ep_valid) begin
         last_d[5] = result_in.is_in;
         last_d[2:0] = other_ep_done;
      end
      last_d[4:3] = 2'h0;
      fault_d = fault_q;
      if (fault_in.valid) begin
         fault_d = fault_in.code;
      end else if (!flags_d[ufc_pkg::EV_ERR]) begin
         fault_d = 3'h0;
      end
   end

   // ----------------------------------------------------------------
   // Control pipe
   // ----------------------------------------------------------------
   always_comb begin
      done_d = done_q;
      txtog_d = txtog_q;
      rxtog_d = rxtog_q;
      txhs_d = txhs_q;
      rxhs_d = rxhs_q;
      if (wr_pipe) begin
         done_d = done_q & wd[7];
         txtog_d = wd[6];
         txhs_d = wd[5:4];
         rxtog_d = wd[2];
         rxhs_d = wd[1:0];
      end
      if (tok_ep0 && is_setup && reply_hs != ufc_pkg::HS_DISABLED) begin
         txtog_d = 1'b1;
         rxtog_d = 1'b0;
         txhs_d = ufc_pkg::HS_NAK;
         rxhs_d = ufc_pkg::HS_NAK;
      end
      if (cur_ep_q == 3'h0 && result_in.ack_rx) begin
         txtog_d = ~txtog_q;
      end
      if (cur_ep_q == 3'h0 && result_in.data_ok) begin
         rxtog_d = ~rxtog_q;
      end
      if (ep0_ok) begin
         done_d = 1'b1;
         txhs_d = ufc_pkg::HS_NAK;
         rxhs_d = ufc_pkg::HS_NAK;
      end
      if (usb_rst) begin
         txtog_d = 1'b0;
         txhs_d = ufc_pkg::HS_DISABLED;
         rxtog_d = 1'b0;
         rxhs_d = ufc_pkg::HS_DISABLED;
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   wire [7:0] pipe_rd = {done_q, txtog_q, txhs_q, 1'b0, rxtog_q,
      rxhs_q};
   wire [7:0] rd_byte = hit_flags ? flags_q :
      hit_mask ? mask_q :
      hit_lctl ? lctl_q :
      hit_node ? {1'b0, node_q} :
      hit_last ? last_q :
      hit_fault ? {5'h00, fault_q} :
      hit_pipe ? pipe_rd : 8'h00;
   wire irq_d = |(flags_q & mask_q) && !cpu_irq_disable;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= ufc_pkg::RST_ZERO;
         mask_q <= ufc_pkg::RST_ZERO;
         lctl_q <= ufc_pkg::RST_LINK_CONTROL;
         node_q <= 7'h00;
         last_q <= ufc_pkg::RST_ZERO;
         fault_q <= 3'h0;
         done_q <= 1'b0;
         txtog_q <= 1'b0;
         rxtog_q <= 1'b0;
         txhs_q <= ufc_pkg::HS_DISABLED;
         rxhs_q <= ufc_pkg::HS_DISABLED;
         cur_ep_q <= 3'h7;
         cur_pid_q <= ufc_pkg::PID_OUT;
         suspend_q <= ufc_pkg::RST_LINK_CONTROL[ufc_pkg::LC_FORCED_SLEEP];
      end else if (clk_en) begin
         flags_q <= flags_d;
         lctl_q <= lctl_d;
         last_q <= last_d;
         fault_q <= fault_d;
         done_q <= done_d;
         txtog_q <= txtog_d;
         rxtog_q <= rxtog_d;
         txhs_q <= txhs_d;
         rxhs_q <= rxhs_d;
         suspend_q <= lctl_d[ufc_pkg::LC_FORCED_SLEEP];
         if (wr_acc && hit_mask) begin
            mask_q <= wd & ufc_pkg::EV_VALID_MASK;
         end
         if (usb_rst) begin
            node_q <= 7'h00;
         end else if (wr_acc && hit_node) begin
            node_q <= wd[6:0];
         end
         if (tok_mine) begin
            cur_ep_q <= token_in.ep;
            cur_pid_q <= token_in.pid;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs from flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         resume_drive <= 1'b0;
         regulator_off <= 1'b1;
         suspended <= 1'b1;
         iface_reset <= 1'b0;
         ep0_handshake <= ufc_pkg::HS_DISABLED;
         ep0_reply_valid <= 1'b0;
         ep0_toggle <= 1'b0;
      end else if (clk_en) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit_any;
         if (rd_acc) begin
            prdata <= {24'h000000, rd_byte};
         end
         irq <= irq_d;
         resume_drive <= lctl_d[ufc_pkg::LC_RESUME];
         regulator_off <= lctl_d[ufc_pkg::LC_REGULATOR_OFF];
         suspended <= lctl_d[ufc_pkg::LC_FORCED_SLEEP];
         iface_reset <= lctl_d[ufc_pkg::LC_FORCE_RESET];
         ep0_reply_valid <= tok_ep0 && reply_hs != ufc_pkg::HS_DISABLED;
         ep0_handshake <= reply_hs;
         // A SETUP data stage always starts on DATA0
         ep0_toggle <= (token_in.pid == ufc_pkg::PID_IN) ? txtog_q :
            (is_setup ? 1'b0 : rxtog_q);
      end
   end
endmodule // ufc_ctrl

/* hw/ufc_pkg.sv */
package ufc_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_EVENT_FLAGS = 12'h000;
   localparam logic [11:0] OFF_EVENT_MASK = 12'h004;
   localparam logic [11:0] OFF_LINK_CONTROL = 12'h008;
   localparam logic [11:0] OFF_NODE_ID = 12'h00C;
   localparam logic [11:0] OFF_LAST_XFER = 12'h010;
   localparam logic [11:0] OFF_FAULT_KIND = 12'h014;
   localparam logic [11:0] OFF_CONTROL_PIPE = 12'h018;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_LINK_CONTROL = 8'h06;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // Bit positions
   // ----------------------------------------------------------------
   localparam int EV_CTR = 7;
   localparam int EV_SOVR = 5;
   localparam int EV_ERR = 4;
   localparam int EV_SUSP = 3;
   localparam int EV_SUSPEND_EXIT_EVENT = 2;
   localparam int EV_RESET = 1;
   localparam int EV_SOF = 0;
   localparam logic [7:0] EV_VALID_MASK = 8'hBF;
   localparam int LC_RESUME_SEEN = 7;
   localparam int LC_BUS_RESET_SEEN = 6;
   localparam int LC_RESUME = 3;
   localparam int LC_REGULATOR_OFF = 2;
   localparam int LC_FORCED_SLEEP = 1;
   localparam int LC_FORCE_RESET = 0;

   // ----------------------------------------------------------------
   // Handshake codes and PID tags
   // ----------------------------------------------------------------
   localparam logic [1:0] HS_DISABLED = 2'h0;
   localparam logic [1:0] HS_STALL = 2'h1;
   localparam logic [1:0] HS_NAK = 2'h2;
   localparam logic [1:0] HS_VALID = 2'h3;
   localparam logic [1:0] PID_OUT = 2'h0;
   localparam logic [1:0] PID_IN = 2'h2;
   localparam logic [1:0] PID_SETUP = 2'h3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int REG_SETTLE_NS = 3000;
   localparam int REG_SETTLE_CYC =
      (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;       // One-cycle token report
      logic [6:0] node;  // Device number field of token
      logic [2:0] ep;    // Endpoint number
      logic [1:0] pid;   // Upper PID bits
   } ufc_token_s;

   typedef struct packed {
      logic ok;          // Transfer completed correctly
      logic ack_rx;      // ACK from host after our data
      logic data_ok;     // Data packet with matching toggle
      logic is_in;       // Direction of transfer
   } ufc_result_s;

   typedef struct packed {
      logic valid;       // One-cycle error report
      logic [2:0] code;  // Fault kind
   } ufc_fault_s;

   typedef struct packed {
      logic bus_reset;   // Reset sequence started on bus
      logic resume;      // Resume sequence started
      logic activity;    // Any bus activity
      logic idle_susp;   // Idle long enough for suspend
      logic sof;         // Start-of-frame token
   } ufc_line_s;
endpackage

/* tb/ufc_ctrl_properties.sv */
`timescale 1ns/1ps
module ufc_ctrl_properties (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic clk_en, // Enable
   input wire logic psel, // Select
   input wire logic penable, // Access
   input wire logic pwrite, // Direction
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic pready, // Ready
   input wire logic cpu_irq_disable, // Global disable
   input wire ufc_pkg::ufc_line_s line_in, // Line events
   input wire ufc_pkg::ufc_token_s token_in, // Token
   input wire logic irq, // Interrupt
   input wire logic resume_drive, // Resume
   input wire logic regulator_off, // Regulator
   input wire logic suspended, // Suspend
   input wire logic iface_reset, // Held reset
   input wire logic ep0_reply_valid // Reply
);
   wire lc_wr = psel && penable && pwrite && clk_en &&
      paddr == ufc_pkg::OFF_LINK_CONTROL;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_SETUP_READY:
      assert property (psel && !penable && clk_en |=> pready)
      else $error("no ready after setup");
   AST_IRQ_BLOCKED:
      assert property (cpu_irq_disable && clk_en |=> !irq)
      else $error("irq while disabled");
   AST_RESUME_WRITE:
      assert property (lc_wr |=> resume_drive == $past(pwdata[3]))
      else $error("resume drive not written");
   AST_REGULATOR_WRITE:
      assert property (lc_wr |=> regulator_off == $past(pwdata[2]))
      else $error("regulator not written");
   AST_FORCE_RESET_WRITE:
      assert property (lc_wr |=> iface_reset == $past(pwdata[0]))
      else $error("interface reset not written");
   AST_WAKE:
      assert property (suspended && line_in.activity && clk_en && !lc_wr
         |=> !suspended)
      else $error("activity left interface suspended");
   AST_REPLY_CAUSE:
      assert property (ep0_reply_valid |->
         $past(token_in.valid) && $past(token_in.ep) == 3'h0)
      else $error("reply without endpoint 0 token");
   AST_HELD_NO_REPLY:
      assert property (iface_reset && token_in.valid |=> !ep0_reply_valid)
      else $error("reply while interface held in reset");
   AST_RESET_VALUE:
      assert property ($rose(presetn) |->
         regulator_off && suspended && !iface_reset && !resume_drive)
      else $error("link outputs wrong after reset");
endmodule // ufc_ctrl_properties

bind ufc_ctrl ufc_ctrl_properties u_props (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .cpu_irq_disable(cpu_irq_disable), .line_in(line_in),
   .token_in(token_in), .irq(irq), .resume_drive(resume_drive),
   .regulator_off(regulator_off), .suspended(suspended),
   .iface_reset(iface_reset), .ep0_reply_valid(ep0_reply_valid));

/* tb/ufc_ctrl_tb_top.sv */
`timescale 1ns/1ps
module ufc_ctrl_tb_top;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} ufc_note_s;
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0;
   logic penable = 1'b0, pwrite = 1'b0, cpu_irq_disable = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, resume_drive, regulator_off, suspended;
   logic iface_reset, ep0_reply_valid, ep0_toggle, other_ep_valid;
   logic [1:0] ep0_handshake;
   logic [2:0] other_ep_done, e;
   ufc_pkg::ufc_line_s line_in;
   ufc_pkg::ufc_token_s token_in;
   ufc_pkg::ufc_result_s result_in;
   ufc_pkg::ufc_fault_s fault_in;
   ufc_note_s rdq[$];
   logic [2:0] hsq[$];
   logic [2:0] fcodes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
   logic [7:0] rstv [7] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] v;
   logic [6:0] n;
   logic d;
   int fails = 0, comparisons = 0, cyc = 0;

   ufc_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_irq_disable(cpu_irq_disable), .line_in(line_in),
      .token_in(token_in), .result_in(result_in), .fault_in(fault_in),
      .other_ep_done(other_ep_done), .other_ep_valid(other_ep_valid),
      .irq(irq), .resume_drive(resume_drive), .regulator_off(regulator_off),
      .suspended(suspended), .iface_reset(iface_reset),
      .ep0_handshake(ep0_handshake), .ep0_reply_valid(ep0_reply_valid),
      .ep0_toggle(ep0_toggle));
   ufc_host_model host (.pclk(pclk), .line_in(line_in), .token_in(token_in),
      .result_in(result_in), .fault_in(fault_in),
      .other_ep_done(other_ep_done), .other_ep_valid(other_ep_valid));

   always #5 pclk = ~pclk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("fails %0d, comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] x);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, x};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Offsets above 018h expect the error response
   task automatic rd(input logic [11:0] a, input logic [7:0] x,
                     input logic [7:0] m = 8'hFF);
      rdq.push_back('{32'(x), 32'(m), a > 12'h018});
      apb(1'b0, a, 8'h00);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] x);
      rdq.push_back('{32'h0, 32'h0, a > 12'h018});
      apb(1'b1, a, x);
   endtask

   always @(posedge pclk) begin : mon
      ufc_note_s nt;
      cyc++;
      if (psel && penable && pready) begin
         nt = rdq.size() ? rdq.pop_front() : ufc_note_s'{32'h0, 32'h0, 1'b1};
         check(prdata & nt.m, nt.d);
         check(32'(pslverr), 32'(nt.e));
      end
      if (ep0_reply_valid)
         check(32'({ep0_toggle, ep0_handshake}),
            hsq.size() ? 32'(hsq.pop_front()) : 32'hFFFFFFFF);
      if (cyc > 5000) begin
         fails++;
         complete_run();
      end
   end

   initial begin
      v = 8'($urandom(9)) & ufc_pkg::EV_VALID_MASK;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) rd(12'(4 * i), rstv[i]);
      rd(12'h01C, 8'h00);
      wr(12'h020, 8'h5A);
      wr(12'h004, v);
      rd(12'h004, v);
      wr(12'h004, 8'h01);
      host.pulse_line(5'b00001);
      rd(12'h000, 8'h01);
      check(32'(irq), 32'h1);
      cpu_irq_disable <= 1'b1;
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0);
      cpu_irq_disable <= 1'b0;
      wr(12'h000, 8'hFF);
      rd(12'h000, 8'h01);
      wr(12'h000, 8'h00);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0);
      clk_en <= 1'b0;
      host.pulse_line(5'b00001);
      clk_en <= 1'b1;
      rd(12'h000, 8'h00);
      check(32'(irq), 32'h0);
      wr(12'h008, 8'h08);
      rd(12'h008, 8'h08);
      check(32'({resume_drive, regulator_off}), 32'h2);
      wr(12'h008, 8'h00);
      repeat (ufc_pkg::REG_SETTLE_CYC) @(posedge pclk);
      wr(12'h008, 8'h02);
      host.pulse_line(5'b01100);
      rd(12'h008, 8'h80);
      check(32'(suspended), 32'h0);
      rd(12'h000, 8'h04);
      wr(12'h000, 8'h00);
      host.pulse_line(5'b00010);
      rd(12'h000, 8'h08);
      wr(12'h000, 8'h00);
      n = 7'($urandom_range(127, 1));
      wr(12'h00C, {1'b1, n});
      rd(12'h00C, {1'b0, n});
      host.pulse_line(5'b10000);
      rd(12'h008, 8'h40, 8'h40);
      rd(12'h00C, 8'h00);
      rd(12'h000, 8'h02);
      wr(12'h000, 8'h00);
      wr(12'h00C, {1'b0, n});
      wr(12'h008, 8'h01);
      host.tok(n, 3'h0, ufc_pkg::PID_SETUP);
      rd(12'h00C, 8'h00);
      wr(12'h008, 8'h00);
      rd(12'h000, 8'h02);
      wr(12'h000, 8'h00);
      wr(12'h00C, {1'b0, n});
      for (int c = 0; c < 3; c++) begin
         wr(12'h018, 8'(c * 17));
         rd(12'h018, 8'(c * 17));
         repeat (2) if (c != 0) hsq.push_back(3'(c));
         host.tok(n, 3'h0, ufc_pkg::PID_IN);
         host.tok(n, 3'h0, ufc_pkg::PID_OUT);
      end
      wr(12'h018, 8'h37);
      host.tok(n ^ 7'h01, 3'h0, ufc_pkg::PID_IN);
      hsq.push_back({1'b0, ufc_pkg::HS_VALID});
      host.tok(n, 3'h0, ufc_pkg::PID_SETUP);
      host.res(4'b1000);
      rd(12'h018, 8'hE2);
      rd(12'h010, 8'hC0, 8'hC7);
      rd(12'h000, 8'h80);
      hsq.push_back({1'b1, ufc_pkg::HS_NAK});
      host.tok(n, 3'h0, ufc_pkg::PID_IN);
      wr(12'h018, 8'h73);
      hsq.push_back({1'b1, ufc_pkg::HS_VALID});
      host.tok(n, 3'h0, ufc_pkg::PID_IN);
      host.res(4'b1101);
      rd(12'h018, 8'hA2);
      rd(12'h010, 8'h80, 8'hC7);
      wr(12'h018, 8'h03);
      hsq.push_back({1'b0, ufc_pkg::HS_VALID});
      host.tok(n, 3'h0, ufc_pkg::PID_OUT);
      host.res(4'b1010);
      rd(12'h018, 8'hA6);
      rd(12'h010, 8'h00, 8'hC7);
      e = 3'($urandom_range(5, 1));
      d = 1'($urandom);
      host.oth(e, d);
      rd(12'h010, {2'b00, d, 2'b00, e}, 8'h27);
      foreach (fcodes[i]) begin
         host.flt(fcodes[i]);
         rd(12'h014, {5'h00, fcodes[i]});
         wr(12'h000, 8'hEF);
         rd(12'h014, 8'h00);
      end
      check(32'(hsq.size()), 32'h0);
      complete_run();
   end
endmodule // ufc_ctrl_tb_top

/* tb/ufc_host_model.sv */
`timescale 1ns/1ps
module ufc_host_model (
   input wire logic pclk, // Clock
   output ufc_pkg::ufc_line_s line_in, // Line events
   output ufc_pkg::ufc_token_s token_in, // Tokens
   output ufc_pkg::ufc_result_s result_in, // Results
   output ufc_pkg::ufc_fault_s fault_in, // Faults
   output logic [2:0] other_ep_done, // Endpoint
   output logic other_ep_valid // Endpoint done
);
   initial begin
      line_in = '0;
      token_in = '0;
      result_in = '0;
      fault_in = '0;
      other_ep_done = 3'h0;
      other_ep_valid = 1'b0;
   end

   // One-cycle pulses; line and result fields return to zero, token, fault and endpoint fields carry inverted junk
   task automatic pulse_line(input logic [4:0] l);
      @(posedge pclk);
      line_in <= l;
      @(posedge pclk);
      line_in <= '0;
   endtask

   task automatic tok(input logic [6:0] n, input logic [2:0] e,
                      input logic [1:0] p);
      @(posedge pclk);
      token_in <= {1'b1, n, e, p};
      @(posedge pclk);
      token_in <= {1'b0, ~n, ~e, ~p};
   endtask

   task automatic res(input logic [3:0] r);
      @(posedge pclk);
      result_in <= r;
      @(posedge pclk);
      result_in <= '0;
   endtask

   task automatic flt(input logic [2:0] c);
      @(posedge pclk);
      fault_in <= {1'b1, c};
      @(posedge pclk);
      fault_in <= {1'b0, ~c};
   endtask

   task automatic oth(input logic [2:0] e, input logic i);
      @(posedge pclk);
      other_ep_valid <= 1'b1;
      other_ep_done <= e;
      result_in <= {3'h0, i};
      @(posedge pclk);
      other_ep_valid <= 1'b0;
      other_ep_done <= ~e;
      result_in <= '0;
   endtask
endmodule // ufc_host_model
